// ### shared/sr_pkg.sv
// What this block does
// - Startup or rate change enters fast servo mode
// - Servo settled near value returns to slow
// - Fast mode holds settling mute flag set
// - Group delay bit 7 soft-mutes the output
// - Slow-mode entry may raise an interrupt
// - 64 taps, or 64 times in/out ratio
// - Each output period loads RAM/ROM start pointers
// - RAM address decrements by one per tap
// - ROM step 2^20, scaled by out/in ratio
// - ROM pointer wrap ends the convolution
// - Left and right share one MAC
// - Ratio from output versus input counters
// - Decimation ratio adjusts fetched coefficients
// - Upsampling holds ratio at unity
// - Ratio updates only beyond two-period difference
// - Clock control selects four sources, divider
// - Write offset is 16 plus delay bits
// - Sample RAM holds 512 words per channel
// - Decimating inputs scaled by out/in ratio
`default_nettype none
package sr_pkg;
  // Register offsets
  localparam logic [3:0] SR_OFS_CLK_CTRL = 4'h0;
  localparam logic [3:0] SR_OFS_GDELAY = 4'h1;
  localparam logic [3:0] SR_OFS_ERROR = 4'h2;
  localparam logic [3:0] SR_OFS_RATIO = 4'h3;
  // Field positions
  localparam int SR_BIT_MUTE = 7;
  localparam int SR_BIT_DIV_EN = 2;
  localparam int SR_BIT_FLAG = 0;
  localparam int SR_BIT_IRQ_EN = 1;
  localparam int SR_BIT_SLOW_SEEN = 2;
  // Reset values
  localparam logic [7:0] SR_RST_CLK_CTRL = 8'h00;
  localparam logic [7:0] SR_RST_GDELAY = 8'h00;
  // Datapath constants
  localparam int SR_FRAC = 20;
  localparam logic [8:0] SR_BASE_TAPS = 9'h040;
  localparam logic [8:0] SR_MAX_TAPS = 9'h1F0;
  localparam logic [8:0] SR_MIN_OFFSET = 9'h010;
  localparam logic [9:0] SR_HYST = 10'h002;
  localparam logic [5:0] SR_WIN_LAST = 6'h3F;
  localparam logic [20:0] SR_UNITY_STEP = 21'h10_0000;
  localparam logic [8:0] SR_GAIN_FULL = 9'h100;
  localparam logic [4:0] SR_DIV_FIRST = 5'h1A;
  // Servo loop gains and settling threshold
  localparam int SR_KP_FAST = 3;
  localparam int SR_KI_FAST = 6;
  localparam int SR_KP_SLOW = 7;
  localparam int SR_KI_SLOW = 12;
  localparam logic [28:0] SR_SETTLE_THR = 29'h0004_0000;
  localparam logic [28:0] SR_INC_RST = 29'h0010_0000;
  typedef enum logic {SR_CV_IDLE, SR_CV_RUN} sr_cv_t;
endpackage : sr_pkg
`default_nettype wire

// ### src/sr_core.sv
`default_nettype none
module sr_core #(
  parameter int RAM_DEPTH = 512,
  parameter int DW = 24
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Input sample stream
  input wire logic in_strobe,
  input wire logic signed [DW-1:0] in_left,
  input wire logic signed [DW-1:0] in_right,
  // Output sample stream
  input wire logic out_strobe,
  output logic signed [DW-1:0] out_left,
  output logic signed [DW-1:0] out_right,
  output logic out_valid,
  // Master clock selection and status
  output logic [1:0] mclk_src_sel,
  output logic mclk_div_en,
  output logic settling_mute_flag,
  output logic slow_mode_irq
);
  import sr_pkg::*;

  localparam int AW = $clog2(RAM_DEPTH);

  // Absolute value of a servo-width signed quantity
  function automatic logic [28:0] sr_abs(input logic signed [28:0] v);
    return v < 0 ? 29'(-v) : 29'(v);
  endfunction : sr_abs

  // Sample scaled by out/in step and by mute gain
  function automatic logic signed [DW-1:0] sr_scale(input logic signed [DW-1:0] s,
      input logic [20:0] st, input logic [8:0] g);
    logic signed [DW+21:0] a;
    logic signed [DW+10:0] b;
    a = s * $signed({1'b0, st});
    b = $signed(a[DW+20:SR_FRAC]) * $signed({1'b0, g});
    return b[DW+7:8];
  endfunction : sr_scale

  // Coefficient lookup, triangular window over ROM pointer
  function automatic logic signed [16:0] sr_coef(input logic [25:0] p);
    logic [8:0] t;
    t = p[25] ? ~p[24:16] : p[24:16];
    return {1'b0, t, 7'h00};
  endfunction : sr_coef

  logic [7:0] clk_ctrl_reg;
  logic [7:0] gdelay_reg;
  logic irq_en_reg;
  logic slow_seen_reg;
  logic fast_reg;
  logic slow_evt;
  logic rate_chg;
  logic [AW-1:0] in_idx_reg;
  logic [8:0] gain_reg;
  logic signed [DW-1:0] ram_l [RAM_DEPTH];
  logic signed [DW-1:0] ram_r [RAM_DEPTH];
  logic [5:0] win_cnt_reg;
  logic [9:0] in_win_reg;
  logic [9:0] last_cnt_reg;
  logic [8:0] ratio_reg;
  logic [9:0] diff;
  logic [8:0] ratio_next;
  logic div_busy_reg;
  logic [4:0] div_i_reg;
  logic [9:0] div_rem_reg;
  logic [26:0] div_q_reg;
  logic [9:0] div_r;
  logic div_ge;
  logic [20:0] step_reg;
  logic [28:0] ph_reg;
  logic signed [28:0] inc_reg;
  logic signed [28:0] err;
  logic [26:0] rom_start;
  logic [40:0] rom_prod;
  sr_cv_t cv_reg;
  logic chan_reg;
  logic [AW-1:0] addr_reg;
  logic [AW-1:0] ld_addr_reg;
  logic [26:0] rp_reg;
  logic [25:0] ld_rp_reg;
  logic [26:0] rp_sum;
  logic signed [47:0] acc_reg;
  logic signed [DW-1:0] left_hold_reg;
  logic signed [DW-1:0] tap_smp;

  // Register writes
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      clk_ctrl_reg <= SR_RST_CLK_CTRL;
      gdelay_reg <= SR_RST_GDELAY;
      irq_en_reg <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == SR_OFS_CLK_CTRL) clk_ctrl_reg <= reg_wdata[7:0];
      if (reg_addr == SR_OFS_GDELAY) gdelay_reg <= reg_wdata[7:0];
      if (reg_addr == SR_OFS_ERROR) irq_en_reg <= reg_wdata[SR_BIT_IRQ_EN];
    end
  end

  // Clock source and divider drive the clock tree
  assign mclk_src_sel = clk_ctrl_reg[1:0];
  assign mclk_div_en = clk_ctrl_reg[SR_BIT_DIV_EN];

  // Register reads, data one cycle after strobe
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        SR_OFS_CLK_CTRL: reg_rdata <= {8'h00, clk_ctrl_reg};
        SR_OFS_GDELAY: reg_rdata <= {8'h00, gdelay_reg};
        SR_OFS_ERROR: reg_rdata <= {13'h0000, slow_seen_reg, irq_en_reg, fast_reg};
        SR_OFS_RATIO: reg_rdata <= {7'h00, ratio_reg};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Slow-mode event latch, set wins over clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      slow_seen_reg <= 1'b0;
    end else if (slow_evt) begin
      slow_seen_reg <= 1'b1;
    end else if (reg_wr && reg_addr == SR_OFS_ERROR && reg_wdata[SR_BIT_SLOW_SEEN]) begin
      slow_seen_reg <= 1'b0;
    end
  end

  assign slow_mode_irq = slow_seen_reg & irq_en_reg;
  assign settling_mute_flag = fast_reg;

  // Soft-mute gain ramp, one step per input sample
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      gain_reg <= 9'h000;
    end else if (in_strobe) begin
      if (gdelay_reg[SR_BIT_MUTE]) begin
        if (gain_reg != 9'h000) gain_reg <= gain_reg - 9'h001;
      end else if (gain_reg != SR_GAIN_FULL) begin
        gain_reg <= gain_reg + 9'h001;
      end
    end
  end

  // Input write index
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) in_idx_reg <= '0;
    else if (in_strobe) in_idx_reg <= in_idx_reg + 1'b1;
  end

  // Scaled, muted samples written ahead of the read pointer
  always_ff @(posedge clock) begin
    if (in_strobe) begin
      ram_l[AW'(in_idx_reg + AW'(SR_MIN_OFFSET) + AW'(gdelay_reg[6:0]))] <=
        sr_scale(in_left, step_reg, gain_reg);
      ram_r[AW'(in_idx_reg + AW'(SR_MIN_OFFSET) + AW'(gdelay_reg[6:0]))] <=
        sr_scale(in_right, step_reg, gain_reg);
    end
  end

  // Rate window: input count over a fixed output-period window
  assign diff = (in_win_reg > last_cnt_reg) ? in_win_reg - last_cnt_reg : last_cnt_reg - in_win_reg;
  assign rate_chg = out_strobe && win_cnt_reg == SR_WIN_LAST && diff > SR_HYST;
  always_comb begin
    if (in_win_reg <= 10'(SR_BASE_TAPS)) ratio_next = SR_BASE_TAPS;
    else if (in_win_reg >= 10'(SR_MAX_TAPS)) ratio_next = SR_MAX_TAPS;
    else ratio_next = in_win_reg[8:0];
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      win_cnt_reg <= 6'h00;
      in_win_reg <= 10'h000;
      last_cnt_reg <= 10'(SR_BASE_TAPS);
      ratio_reg <= SR_BASE_TAPS;
    end else begin
      if (out_strobe) win_cnt_reg <= win_cnt_reg + 6'h01;
      if (out_strobe && win_cnt_reg == SR_WIN_LAST) begin
        in_win_reg <= {9'h000, in_strobe};
        if (rate_chg) begin
          last_cnt_reg <= in_win_reg;
          ratio_reg <= ratio_next;
        end
      end else if (in_strobe && in_win_reg != 10'h3FF) begin
        in_win_reg <= in_win_reg + 10'h001;
      end
    end
  end

  // ROM step = 2^26 / taps by restoring division
  assign div_r = {div_rem_reg[8:0], div_i_reg == SR_DIV_FIRST};
  assign div_ge = div_r >= {1'b0, ratio_reg};
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_busy_reg <= 1'b0;
      div_i_reg <= SR_DIV_FIRST;
      div_rem_reg <= 10'h000;
      div_q_reg <= 27'h000_0000;
      step_reg <= SR_UNITY_STEP;
    end else if (!div_busy_reg) begin
      if (rate_chg) begin
        div_busy_reg <= 1'b1;
        div_i_reg <= SR_DIV_FIRST;
        div_rem_reg <= 10'h000;
        div_q_reg <= 27'h000_0000;
      end
    end else begin
      div_rem_reg <= div_ge ? div_r - {1'b0, ratio_reg} : div_r;
      div_q_reg <= {div_q_reg[25:0], div_ge};
      div_i_reg <= div_i_reg - 5'h01;
      if (div_i_reg == 5'h00) begin
        div_busy_reg <= 1'b0;
        step_reg <= {div_q_reg[19:0], div_ge};
      end
    end
  end

  // Servo loop error: input position against ramp
  assign err = $signed({in_idx_reg, SR_FRAC'(0)} - ph_reg);

  // Ramp filter with fast and slow gains
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ph_reg <= 29'h0000_0000;
      inc_reg <= SR_INC_RST;
    end else if (out_strobe) begin
      if (fast_reg) begin
        ph_reg <= ph_reg + 29'(inc_reg) + 29'(err >>> SR_KP_FAST);
        inc_reg <= inc_reg + (err >>> SR_KI_FAST);
      end else begin
        ph_reg <= ph_reg + 29'(inc_reg) + 29'(err >>> SR_KP_SLOW);
        inc_reg <= inc_reg + (err >>> SR_KI_SLOW);
      end
    end
  end

  // Fast on reset and rate change, slow only at a window end that confirmed the rate
  assign slow_evt = out_strobe && win_cnt_reg == SR_WIN_LAST && fast_reg && !rate_chg &&
    sr_abs(err) < SR_SETTLE_THR;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) fast_reg <= 1'b1;
    else if (rate_chg) fast_reg <= 1'b1;
    else if (slow_evt) fast_reg <= 1'b0;
  end

  // ROM start is the ramp fraction divided by in/out ratio
  assign rom_prod = 41'(ph_reg[SR_FRAC-1:0]) * 41'(step_reg);
  assign rom_start = 27'(rom_prod >> SR_FRAC);

  // Convolution engine, left then right on one MAC
  assign tap_smp = chan_reg ? ram_r[addr_reg] : ram_l[addr_reg];
  assign rp_sum = rp_reg + {6'h00, step_reg};
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cv_reg <= SR_CV_IDLE;
      chan_reg <= 1'b0;
      addr_reg <= '0;
      ld_addr_reg <= '0;
      rp_reg <= 27'h000_0000;
      ld_rp_reg <= 26'h000_0000;
      acc_reg <= 48'sh0000_0000_0000;
      left_hold_reg <= '0;
      out_left <= '0;
      out_right <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      unique case (cv_reg)
        SR_CV_IDLE: begin
          if (out_strobe) begin
            addr_reg <= ph_reg[SR_FRAC+AW-1:SR_FRAC];
            ld_addr_reg <= ph_reg[SR_FRAC+AW-1:SR_FRAC];
            rp_reg <= rom_start;
            ld_rp_reg <= rom_start[25:0];
            chan_reg <= 1'b0;
            acc_reg <= 48'sh0000_0000_0000;
            cv_reg <= SR_CV_RUN;
          end
        end
        SR_CV_RUN: begin
          addr_reg <= addr_reg - 1'b1;
          rp_reg <= {1'b0, rp_sum[25:0]};
          acc_reg <= acc_reg + 48'(tap_smp * sr_coef(rp_reg[25:0]));
          if (rp_sum[26]) begin
            acc_reg <= 48'sh0000_0000_0000;
            addr_reg <= ld_addr_reg;
            rp_reg <= {1'b0, ld_rp_reg};
            if (!chan_reg) begin
              left_hold_reg <= DW'(acc_reg[43:20]);
              chan_reg <= 1'b1;
            end else begin
              out_left <= left_hold_reg;
              out_right <= DW'(acc_reg[43:20]);
              out_valid <= 1'b1;
              cv_reg <= SR_CV_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule : sr_core
`default_nettype wire

// ### test/sr_core_sva.sv
`default_nettype none
module sr_checker #(
  parameter int RAM_DEPTH = 512,
  parameter int DW = 24
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Streams and status
  input wire logic out_strobe,
  input wire logic out_valid,
  input wire logic [1:0] mclk_src_sel,
  input wire logic mclk_div_en,
  input wire logic settling_mute_flag,
  input wire logic slow_mode_irq
);
  import sr_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [10:0] since_reg;
  // Cycles since the last output period start
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      since_reg <= 11'h000;
    end else if (out_strobe) begin
      since_reg <= 11'h001;
    end else if (since_reg != 11'h7FF) begin
      since_reg <= since_reg + 11'h001;
    end
  end
  // Bus steps
  sequence ctl_write;
    reg_wr && reg_addr == SR_OFS_CLK_CTRL;
  endsequence
  sequence err_read;
    reg_rd && reg_addr == SR_OFS_ERROR;
  endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read");
  a_src_write: assert property (ctl_write |=> mclk_src_sel == $past(reg_wdata[1:0]))
    else $error("clock source not taken from write");
  a_div_write: assert property (ctl_write |=> mclk_div_en == $past(reg_wdata[SR_BIT_DIV_EN]))
    else $error("divider enable not taken from write");
  a_ctl_hold: assert property (!(reg_wr && reg_addr == SR_OFS_CLK_CTRL) |=>
    $stable(mclk_src_sel) && $stable(mclk_div_en))
    else $error("clock selection moved without write");
  a_flag_read: assert property (err_read |=> reg_rdata[SR_BIT_FLAG] == $past(settling_mute_flag))
    else $error("error register flag differs from port");
  a_irq_read: assert property (err_read |=> (reg_rdata[1] && reg_rdata[2]) == $past(slow_mode_irq))
    else $error("interrupt level differs from enable and event");
  a_ratio_range: assert property (reg_rd && reg_addr == SR_OFS_RATIO |=>
    reg_rdata[8:0] >= SR_BASE_TAPS && reg_rdata[8:0] <= SR_MAX_TAPS && reg_rdata[15:9] == 7'h00)
    else $error("tap count out of range");
  a_unmapped_zero: assert property (reg_rd && reg_addr > SR_OFS_RATIO |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_valid_pulse: assert property (out_valid |=> !out_valid)
    else $error("result strobe longer than one cycle");
  a_conv_length: assert property (out_valid |-> since_reg >= 11'h078 && since_reg <= 11'h3E8)
    else $error("two-channel convolution length wrong");
  a_conv_done: assert property (out_strobe |-> ##[120:1000] out_valid)
    else $error("convolution did not finish");
endmodule : sr_checker
bind sr_core sr_checker #(.RAM_DEPTH(RAM_DEPTH), .DW(DW)) sr_checker_inst (.clock(clock), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .out_strobe(out_strobe), .out_valid(out_valid), .mclk_src_sel(mclk_src_sel), .mclk_div_en(mclk_div_en),
  .settling_mute_flag(settling_mute_flag), .slow_mode_irq(slow_mode_irq));
`default_nettype wire

// ### test/sr_stream_model.sv
`default_nettype none
module sr_stream_model #(
  parameter int DW = 24
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Rates in clock cycles
  input wire logic [15:0] in_period,
  input wire logic [15:0] out_period,
  // Streams
  output logic in_strobe,
  output logic signed [DW-1:0] in_left,
  output logic signed [DW-1:0] in_right,
  output logic out_strobe
);
  logic [15:0] in_cnt_reg;
  logic [15:0] out_cnt_reg;
  // Idle data lines show the inverse, never a stale sample
  assign in_left = in_strobe ? DW'(24'h10_0000) : ~DW'(24'h10_0000);
  assign in_right = ~in_left;
  assign in_strobe = in_cnt_reg == 16'h0000 && !sys_rst;
  assign out_strobe = out_cnt_reg == 16'h0000 && !sys_rst;
  // Source rate
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst || in_cnt_reg >= in_period - 16'h0001) begin
      in_cnt_reg <= 16'h0000;
    end else begin
      in_cnt_reg <= in_cnt_reg + 16'h0001;
    end
  end
  // Sink rate
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst || out_cnt_reg >= out_period - 16'h0001) begin
      out_cnt_reg <= 16'h0000;
    end else begin
      out_cnt_reg <= out_cnt_reg + 16'h0001;
    end
  end
endmodule : sr_stream_model
`default_nettype wire

// ### test/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import sr_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] in_period = 16'h0118;
  logic in_strobe;
  logic out_strobe;
  logic signed [23:0] in_left;
  logic signed [23:0] in_right;
  logic [1:0] mclk_src_sel;
  logic mclk_div_en;
  logic settling_mute_flag;
  logic slow_mode_irq;
  logic signed [23:0] out_left;
  logic signed [23:0] out_right;
  logic out_valid;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  sr_core sr_core_inst (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_strobe(in_strobe), .in_left(in_left),
    .in_right(in_right), .out_strobe(out_strobe), .out_left(out_left), .out_right(out_right),
    .out_valid(out_valid),
    .mclk_src_sel(mclk_src_sel), .mclk_div_en(mclk_div_en), .settling_mute_flag(settling_mute_flag),
    .slow_mode_irq(slow_mode_irq));
  sr_stream_model sr_stream_model_inst (.clock(clock), .sys_rst(sys_rst), .in_period(in_period),
    .out_period(16'h0118), .in_strobe(in_strobe), .in_left(in_left), .in_right(in_right),
    .out_strobe(out_strobe));
  // Clock and hang guard
  initial forever #4 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 100000) begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : reg_write
  task automatic read_check(input logic [3:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    check({8'h00, reg_rdata}, {8'h00, e});
    @(posedge clock);
  endtask : read_check
  task automatic wait_flag(input logic level, input int limit);
    int n;
    n = 0;
    while (settling_mute_flag !== level && n < limit) begin
      @(posedge clock);
      n++;
    end
    check({23'h0, settling_mute_flag}, {23'h0, level});
  endtask : wait_flag
  task automatic test_reset;
    check({23'h0, settling_mute_flag}, 24'h00_0001);
    read_check(SR_OFS_CLK_CTRL, {8'h00, SR_RST_CLK_CTRL});
    read_check(SR_OFS_GDELAY, {8'h00, SR_RST_GDELAY});
    read_check(SR_OFS_ERROR, 16'h0001);
    read_check(SR_OFS_RATIO, {7'h00, SR_BASE_TAPS});
    read_check(4'hF, 16'h0000);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_registers;
    for (int i = 0; i < 8; i++) begin
      reg_write(SR_OFS_CLK_CTRL, 16'hFFF8 | 16'(i));
      check({21'h0, mclk_div_en, mclk_src_sel}, 24'(i));
      read_check(SR_OFS_CLK_CTRL, 16'h00F8 | 16'(i));
    end
    reg_write(SR_OFS_GDELAY, 16'h7F8A);
    read_check(SR_OFS_GDELAY, 16'h008A);
    reg_write(SR_OFS_GDELAY, 16'h0000);
    reg_write(SR_OFS_RATIO, 16'h0000);
    read_check(SR_OFS_RATIO, 16'h0040);
    $display("test_registers done");
  endtask : test_registers
  task automatic test_settle;
    reg_write(SR_OFS_ERROR, 16'h0002);
    wait_flag(1'b0, 40000);
    read_check(SR_OFS_ERROR, 16'h0006);
    check({23'h0, slow_mode_irq}, 24'h00_0001);
    reg_write(SR_OFS_ERROR, 16'h0006);
    read_check(SR_OFS_ERROR, 16'h0002);
    check({23'h0, slow_mode_irq}, 24'h00_0000);
    read_check(SR_OFS_RATIO, 16'h0040);
    $display("test_settle done");
  endtask : test_settle
  task automatic test_rate;
    in_period <= 16'h008C;
    wait_flag(1'b1, 38000);
    read_check(SR_OFS_ERROR, 16'h0003);
    repeat (65) @(posedge out_strobe);
    @(posedge clock);
    read_check(SR_OFS_RATIO, 16'h0080);
    $display("test_rate done");
  endtask : test_rate
  // Right input is the inverse of left, so the results nearly cancel
  task automatic test_output;
    logic signed [24:0] pair_sum;
    @(posedge out_valid);
    @(negedge clock);
    pair_sum = out_left + out_right;
    check({23'h0, out_left > 24'sh00_0000}, 24'h00_0001);
    check((pair_sum <= 0 && pair_sum >= -9) ? 24'h00_0000 : 24'(pair_sum), 24'h00_0000);
    @(posedge clock);
    $display("test_output done");
  endtask : test_output
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    test_reset();
    test_registers();
    test_settle();
    test_rate();
    test_output();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
